// ---- src/ebc_io_cycle.sv ----
`timescale 1ns/10ps
module ebc_io_cycle
    import ebc_pkg::*;
#(
    parameter int unsigned N_SLOTS = 8,
    parameter int unsigned N_EMBED = 2,
    parameter int unsigned W = 8,
    // Clock rate in MHz seen by the cycle timer; a lower rate gives shorter bus cycles
    parameter int unsigned CLK_MHZ = EBC_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire ebc_pkg::ebc_period_t period_sel,
    input wire logic period_load,
    input wire logic [EBC_SLOT_W-1:0] slot_limit,
    input wire logic [N_SLOTS-1:0] slow_mod,
    // Task interface
    input wire ebc_pkg::ebc_task_ev_t task_ev,
    input wire logic [N_SLOTS-1:0] task_use,
    input wire logic [N_SLOTS*W-1:0] task_out,
    // Bus side
    input wire logic [N_SLOTS*W-1:0] phys_in,
    output logic [N_SLOTS*W-1:0] in_image,
    output logic [N_SLOTS*W-1:0] phys_out,
    output logic [N_SLOTS-1:0] phys_upd,
    output logic cycle_strobe,
    output ebc_pkg::ebc_period_t period_cur,
    output logic [EBC_SLOT_W-1:0] slot_limit_cur
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    ebc_period_t period_reg, period_next;
    logic [EBC_SLOT_W-1:0] lim_reg, lim_next;

    // Period and slot limit latched on load, limit clamped
    always_comb begin
        period_next = period_reg;
        lim_next = lim_reg;
        if (period_load) begin
            period_next = (period_sel > EBC_P5MS) ? period_reg : period_sel;
            if (slot_limit > EBC_SLOT_W'(EBC_MAX_SLOTS))
                lim_next = EBC_SLOT_W'(EBC_MAX_SLOTS);
            else if (slot_limit < EBC_SLOT_W'(N_EMBED))
                lim_next = EBC_SLOT_W'(N_EMBED);
            else
                lim_next = slot_limit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_reg <= EBC_PERIOD_RST;
            lim_reg <= EBC_SLOT_W'(EBC_MAX_SLOTS);
        end else begin
            period_reg <= period_next;
            lim_reg <= lim_next;
        end
    end

    // ------------------------------------------------------------
    // Cycle timer
    // ------------------------------------------------------------
    logic cyc;

    ebc_cycle_timer #(
        .CLK_MHZ(CLK_MHZ)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .period_sel(period_reg),
        .cycle_start(cyc)
    );

    // ------------------------------------------------------------
    // Images and output commit
    // ------------------------------------------------------------
    logic [N_SLOTS*W-1:0] in_reg, in_next, out_img_reg, out_img_next, phys_reg, phys_next;
    logic [N_SLOTS-1:0] upd_reg, upd_next, defer_reg, defer_next, en;
    logic pend_reg, pend_next, strobe_reg;

    // Slots beyond the limit are inactive
    always_comb begin
        for (int i = 0; i < N_SLOTS; i++) begin
            en[i] = (i < int'(lim_reg));
        end
    end

    // Image and physical update logic
    always_comb begin
        in_next = in_reg;
        out_img_next = out_img_reg;
        phys_next = phys_reg;
        upd_next = '0;
        defer_next = defer_reg;
        pend_next = pend_reg;
        for (int i = 0; i < N_SLOTS; i++) begin
            if (task_ev.task_start && task_use[i] && en[i])
                in_next[i*W +: W] = phys_in[i*W +: W];
            if (task_ev.task_end && task_use[i] && en[i])
                out_img_next[i*W +: W] = task_out[i*W +: W];
        end
        if (task_ev.task_end && task_ev.is_bus_task)
            pend_next = 1'b1;
        if (cyc) begin
            for (int i = 0; i < N_SLOTS; i++) begin
                if (defer_reg[i]) begin
                    // Slow module finishes a cycle late, unless its slot was retired meanwhile
                    defer_next[i] = 1'b0;
                    if (en[i]) begin
                        phys_next[i*W +: W] = out_img_reg[i*W +: W];
                        upd_next[i] = 1'b1;
                    end
                end else if (pend_reg && en[i]) begin
                    if (slow_mod[i]) begin
                        defer_next[i] = 1'b1;
                    end else begin
                        phys_next[i*W +: W] = out_img_reg[i*W +: W];
                        upd_next[i] = 1'b1;
                    end
                end
            end
            // New bus task end in the same cycle keeps pending
            pend_next = task_ev.task_end && task_ev.is_bus_task;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_reg <= '0;
            out_img_reg <= '0;
            phys_reg <= '0;
            upd_reg <= '0;
            defer_reg <= '0;
            pend_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            in_reg <= in_next;
            out_img_reg <= out_img_next;
            phys_reg <= phys_next;
            upd_reg <= upd_next;
            defer_reg <= defer_next;
            pend_reg <= pend_next;
            strobe_reg <= cyc;
        end
    end

    assign in_image = in_reg;
    assign phys_out = phys_reg;
    assign phys_upd = upd_reg;
    assign cycle_strobe = strobe_reg;
    assign period_cur = period_reg;
    assign slot_limit_cur = lim_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_period_reset: assert property (@(posedge clk) $rose(rst_n) |-> period_reg == EBC_P1MS)
        else $error("period not 1 ms after reset");
    chk_period_legal: assert property (@(posedge clk) disable iff (!rst_n) period_reg <= EBC_P5MS)
        else $error("illegal period code");
    chk_limit_range: assert property (@(posedge clk) disable iff (!rst_n)
        lim_reg <= EBC_SLOT_W'(EBC_MAX_SLOTS) && lim_reg >= EBC_SLOT_W'(N_EMBED))
        else $error("slot limit out of range");
    chk_input_load: assert property (@(posedge clk) disable iff (!rst_n)
        task_ev.task_start && task_use[0] && en[0] |=> in_reg[W-1:0] == $past(phys_in[W-1:0]))
        else $error("input image not loaded");
    chk_output_store: assert property (@(posedge clk) disable iff (!rst_n)
        task_ev.task_end && task_use[0] && en[0] |=> out_img_reg[W-1:0] == $past(task_out[W-1:0]))
        else $error("output image not stored");
    chk_phys_update: assert property (@(posedge clk) disable iff (!rst_n)
        cyc && pend_reg && en[0] && !slow_mod[0] && !defer_reg[0] |=> upd_reg[0] ##0
        phys_reg[W-1:0] == $past(out_img_reg[W-1:0]))
        else $error("physical output not updated");
    chk_slow_defer: assert property (@(posedge clk) disable iff (!rst_n)
        cyc && pend_reg |=> (defer_reg & $past(slow_mod & en & ~defer_reg)) == $past(slow_mod & en & ~defer_reg)
        && (upd_reg & $past(slow_mod & en & ~defer_reg)) == '0)
        else $error("slow module not deferred");
    chk_no_idle_upd: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(cyc) |-> upd_reg == '0)
        else $error("update outside cycle start");
    chk_strobe_single: assert property (@(posedge clk) disable iff (!rst_n) cyc |=> !cyc)
        else $error("double cycle strobe");
    // Images and outputs move only on their own events
    chk_in_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !task_ev.task_start |=> $stable(in_reg))
        else $error("input image changed without task start");
    chk_out_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !task_ev.task_end |=> $stable(out_img_reg))
        else $error("output image changed without task end");
    chk_phys_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !cyc |=> $stable(phys_reg))
        else $error("physical outputs changed between cycle starts");
    chk_period_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !period_load |=> $stable(period_reg))
        else $error("period changed without load");
    // Commit bookkeeping
    chk_pend_arm: assert property (@(posedge clk) disable iff (!rst_n)
        task_ev.task_end && task_ev.is_bus_task |=> pend_reg)
        else $error("bus task end did not arm the commit");
    chk_defer_commit: assert property (@(posedge clk) disable iff (!rst_n)
        cyc |=> (upd_reg & $past(defer_reg & en)) == $past(defer_reg & en))
        else $error("deferred slot not committed");
    chk_inactive_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (upd_reg & ~$past(en)) == '0)
        else $error("inactive slot updated");
    chk_upd_strobe: assert property (@(posedge clk) disable iff (!rst_n)
        |upd_reg |-> strobe_reg)
        else $error("update without cycle strobe");
    chk_limit_reset: assert property (@(posedge clk)
        $rose(rst_n) |-> lim_reg == EBC_SLOT_W'(EBC_MAX_SLOTS))
        else $error("slot limit not at maximum after reset");
    cov_bus_task: cover property (@(posedge clk) disable iff (!rst_n) task_ev.task_end && task_ev.is_bus_task);
    cov_update: cover property (@(posedge clk) disable iff (!rst_n) |upd_reg);
    cov_defer: cover property (@(posedge clk) disable iff (!rst_n) |defer_reg ##1 cyc);
    cov_limit_clamp: cover property (@(posedge clk) disable iff (!rst_n)
        period_load && slot_limit > EBC_SLOT_W'(EBC_MAX_SLOTS));
    cov_short_period: cover property (@(posedge clk) disable iff (!rst_n) cyc && period_reg == EBC_P0_5MS);
endmodule : ebc_io_cycle

// ---- src/ebc_pkg.sv ----
package ebc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned EBC_CLK_MHZ = 250;
    localparam int unsigned EBC_PERIOD_US_0 = 500;   // 0.5 ms
    localparam int unsigned EBC_PERIOD_US_1 = 1000;  // 1 ms
    localparam int unsigned EBC_PERIOD_US_2 = 2000;
    localparam int unsigned EBC_PERIOD_US_3 = 3000;
    localparam int unsigned EBC_PERIOD_US_4 = 4000;
    localparam int unsigned EBC_PERIOD_US_5 = 5000;
    localparam int unsigned EBC_CNT_W = 21;
    localparam int unsigned EBC_MAX_SLOTS = 250;
    localparam int unsigned EBC_SLOT_W = 8;

    // ------------------------------------------------------------
    // Cycle period selection codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EBC_P0_5MS = 3'h0,
        EBC_P1MS = 3'h1,
        EBC_P2MS = 3'h2,
        EBC_P3MS = 3'h3,
        EBC_P4MS = 3'h4,
        EBC_P5MS = 3'h5
    } ebc_period_t;

    localparam ebc_period_t EBC_PERIOD_RST = EBC_P1MS;

    // Task boundary strobes
    typedef struct packed {
        logic task_start;
        logic task_end;
        logic is_bus_task;
    } ebc_task_ev_t;
endpackage : ebc_pkg

// ---- src/ebc_cycle_timer.sv ----
`timescale 1ns/10ps
module ebc_cycle_timer
    import ebc_pkg::*;
#(
    parameter int unsigned CLK_MHZ = EBC_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire ebc_pkg::ebc_period_t period_sel,
    // Status
    output logic cycle_start
);
    localparam logic [EBC_CNT_W-1:0] C0 = EBC_CNT_W'(EBC_PERIOD_US_0 * CLK_MHZ - 1);
    localparam logic [EBC_CNT_W-1:0] C1 = EBC_CNT_W'(EBC_PERIOD_US_1 * CLK_MHZ - 1);
    localparam logic [EBC_CNT_W-1:0] C2 = EBC_CNT_W'(EBC_PERIOD_US_2 * CLK_MHZ - 1);
    localparam logic [EBC_CNT_W-1:0] C3 = EBC_CNT_W'(EBC_PERIOD_US_3 * CLK_MHZ - 1);
    localparam logic [EBC_CNT_W-1:0] C4 = EBC_CNT_W'(EBC_PERIOD_US_4 * CLK_MHZ - 1);
    localparam logic [EBC_CNT_W-1:0] C5 = EBC_CNT_W'(EBC_PERIOD_US_5 * CLK_MHZ - 1);

    logic [EBC_CNT_W-1:0] cnt_reg, cnt_next, reload;
    logic strobe_reg, strobe_next;

    // Reload value from the selected period
    always_comb begin
        case (period_sel)
            EBC_P0_5MS: reload = C0;
            EBC_P1MS: reload = C1;
            EBC_P2MS: reload = C2;
            EBC_P3MS: reload = C3;
            EBC_P4MS: reload = C4;
            EBC_P5MS: reload = C5;
            default: reload = C1;
        endcase
    end

    // Down counter, strobe at wrap
    always_comb begin
        strobe_next = 1'b0;
        cnt_next = cnt_reg - EBC_CNT_W'(1);
        if (cnt_reg == '0) begin
            cnt_next = reload;
            strobe_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= C1;
            strobe_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            strobe_reg <= strobe_next;
        end
    end

    assign cycle_start = strobe_reg;
endmodule : ebc_cycle_timer

// ---- verification/ebc_io_modules.sv ----
`timescale 1ns/10ps
module ebc_io_modules (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus side
    input wire logic refresh,
    input wire logic [63:0] phys_out,
    input wire logic [7:0] phys_upd,
    output logic [63:0] phys_in,
    output logic [63:0] field_out
);
    int seed = 17;

    // Field outputs follow the bus only on slots marked as updated
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            field_out <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (phys_upd[i]) begin
                    field_out[i*8 +: 8] <= phys_out[i*8 +: 8];
                end
            end
        end
    end

    // Field inputs take new states only when asked, so the bench can predict them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phys_in <= '0;
        end else if (refresh) begin
            phys_in <= {$random(seed), $random(seed)};
        end
    end
endmodule : ebc_io_modules

// ---- verification/ebc_io_cycle_test.sv ----
`timescale 1ns/10ps
module ebc_io_cycle_test;
    import ebc_pkg::*;
    localparam logic [7:0] LIM = 8'h06;
    // Clock rate seen by the timer, scaled down so bus cycles last a few thousand clocks
    localparam int unsigned TB_MHZ = 2;
    logic clk = 0, rst_n = 0, period_load = 0, refresh = 0, cycle_strobe;
    ebc_period_t period_sel = EBC_P1MS, period_cur;
    logic [7:0] slot_limit = LIM, slow_mod = 8'h04, task_use = '0, phys_upd, slot_limit_cur, m, act;
    ebc_task_ev_t task_ev = '0;
    logic [63:0] task_out = '0, phys_in, in_image, phys_out, exp_in = '0, exp_out, img = '0, field_out;
    int fails = 0, tests_run = 0, seed = 80344;
    time t0, t1;

    // ----------------------------
    // Clock, design and bus modules
    // ----------------------------
    always #2 clk = ~clk;
    ebc_io_cycle #(.CLK_MHZ(TB_MHZ)) i_ebc_io_cycle (.clk(clk), .rst_n(rst_n), .period_sel(period_sel),
        .period_load(period_load),
        .slot_limit(slot_limit), .slow_mod(slow_mod), .task_ev(task_ev), .task_use(task_use),
        .task_out(task_out), .phys_in(phys_in), .in_image(in_image), .phys_out(phys_out),
        .phys_upd(phys_upd), .cycle_strobe(cycle_strobe), .period_cur(period_cur),
        .slot_limit_cur(slot_limit_cur));
    ebc_io_modules i_ebc_io_modules (.clk(clk), .rst_n(rst_n), .refresh(refresh), .phys_out(phys_out),
        .phys_upd(phys_upd), .phys_in(phys_in), .field_out(field_out));

    // ----------------------------
    // Helpers
    // ----------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Copy masked active slots of src into old
    function automatic logic [63:0] merge(input logic [63:0] old, input logic [63:0] src, input logic [7:0] k);
        for (int i = 0; i < 8; i++) if (k[i] && i < LIM) old[i*8 +: 8] = src[i*8 +: 8];
        return old;
    endfunction : merge

    task automatic load(input logic [2:0] code, input logic [7:0] lim);
        @(posedge clk);
        period_sel <= ebc_period_t'(code);
        slot_limit <= lim;
        period_load <= 1'b1;
        @(posedge clk);
        period_load <= 1'b0;
        #1;
    endtask : load

    // One-clock task event with fresh outputs
    task automatic fire(input ebc_task_ev_t ev, input logic [7:0] k);
        @(posedge clk);
        task_ev <= ev;
        task_use <= k;
        task_out <= {$random(seed), $random(seed)};
        @(posedge clk);
        task_ev <= '0;
        #1;
    endtask : fire

    task automatic wait_strobe();
        int n = 0;
        while (cycle_strobe !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 5000) begin
                fails++;
                give_verdict();
            end
        end
    endtask : wait_strobe

    // ----------------------------
    // Main sequence
    // ----------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t0 = $time;
        #1;
        check(period_cur, EBC_PERIOD_RST);
        check(slot_limit_cur, 8'hFA);
        for (int c = 5; c >= 0; c--) begin
            load(c[2:0], LIM);
            check(period_cur, 64'(c));
        end
        load(3'h7, LIM);
        check(period_cur, EBC_P0_5MS);
        load(3'h0, 8'h01);
        check(slot_limit_cur, 8'h02);
        load(3'h0, 8'hFF);
        check(slot_limit_cur, 8'hFA);
        // Shortest period, still above the slow module's minimum cycle
        load(3'h0, LIM);
        check(slot_limit_cur, LIM);
        // Input snapshots and output images over several tasks, the last one the bus task
        // The first round drives every slot, inactive ones included, as a corner case
        for (int r = 0; r < 4; r++) begin
            m = (r == 0) ? 8'hFF : (8'($random(seed)) | 8'h0C);
            @(posedge clk);
            refresh <= 1'b1;
            @(posedge clk);
            refresh <= 1'b0;
            fire(3'b100, m);
            exp_in = merge(exp_in, phys_in, m);
            check(in_image, exp_in);
            fire({2'b01, r == 3}, m);
            img = merge(img, task_out, m);
        end
        // Every active slot but the slow one commits at an armed cycle start, used or not; the slow one commits at the next start
        act = ~(8'hFF << LIM);
        wait_strobe();
        t1 = $time;
        // First start comes one 1 ms period after release, plus the strobe's register stage
        check((t1 - t0) / 4, 64'(EBC_PERIOD_US_1 * TB_MHZ + 1));
        exp_out = merge('0, img, act & ~slow_mod);
        check(phys_out, exp_out);
        check(phys_upd, act & ~slow_mod);
        @(posedge clk);
        #1;
        wait_strobe();
        check(($time - t1) / 4, 64'(EBC_PERIOD_US_0 * TB_MHZ));
        check(phys_upd, act & slow_mod);
        check(phys_out, merge(exp_out, img, act & slow_mod));
        // Field side latches each slot one clock after its update pulse
        @(posedge clk);
        #1;
        check(field_out, merge(exp_out, img, act & slow_mod));
        give_verdict();
    end
endmodule : ebc_io_cycle_test
